// ### level_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage_one;

  // First stage read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage_one <= '0;
      sync_o <= '0;
    end else begin
      stage_one <= async_i;
      sync_o <= stage_one;
    end
  end
endmodule : level_sync
`default_nettype wire

// ### wake_clock_pkg.sv
// Register map, field layout and timing constants for the wake and clock sequencer
package wake_clock_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [13:0] IDX_MASTER_CLOCK_CONTROL = 14'h1009;
  localparam logic [13:0] IDX_DETECT_STATUS_ONE = 14'h1309;
  localparam logic [13:0] IDX_DETECT_STATUS_TWO = 14'h130A;
  localparam logic [13:0] IDX_WAKEUP_OUTPUT_CONTROL = 14'h1B71;
  localparam logic [13:0] IDX_MIC_DETECT_CONTROL_ONE = 14'h1B75;
  localparam logic [13:0] IDX_EVENT_STATUS = 14'h1800;
  localparam logic [13:0] IDX_EVENT_MASK = 14'h1801;
  localparam logic [13:0] IDX_POWER_CONTROL = 14'h1802;
  localparam logic [13:0] IDX_CLOCK_STATUS = 14'h1803;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int MCC_RATE_SEL = 1;       // internal_rate_select
  localparam int WOC_MASK_MIC = 7;
  localparam int WOC_MASK_HP = 6;        // mask_headphone_wakeup
  localparam int WOC_LATCH_MODE = 5;     // wakeup_output_latch_mode
  localparam int WOC_CLEAR = 0;          // wakeup_output_clear
  localparam int MDC_LATCH_XFER = 7;
  localparam int MDC_EVENT_SEL = 6;
  localparam int S1_BIAS_HI = 7;         // headset_bias_sense_state 7:6
  localparam int S1_TIP_INSERT = 5;
  localparam int S1_TIP_REMOVE = 4;
  localparam int S2_FALL = 7;
  localparam int S2_RISE = 6;
  localparam int S2_SHORT_RELEASE = 4;
  localparam int S2_SHORT_FOUND = 3;
  localparam int PWR_PLL_ENABLE = 0;
  localparam int PWR_CLAMP_OFF = 1;      // headset_clamp_off
  localparam int PWR_STANDBY_REQ = 2;
  localparam int EV_INSERT = 0;
  localparam int EV_REMOVE = 1;
  localparam int EV_RISE = 2;
  localparam int EV_FALL = 3;
  localparam int EV_SHORT = 4;
  localparam int EV_RELEASE = 5;
  localparam int EV_PLL_READY = 6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MASTER_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] RST_WAKEUP_OUTPUT_CONTROL = 8'hC0;
  localparam logic [7:0] RST_MIC_DETECT_CONTROL = 8'h1F;
  localparam logic [7:0] RST_EVENT_MASK = 8'hFF;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int PLL_SETTLE_MS = 1;
  localparam int PLL_SETTLE_CYCLES = PLL_SETTLE_MS * (CLK_FREQ_HZ / 1000);
  localparam int RATE_DIV_LOW = 250;
  localparam int RATE_DIV_HIGH = 256;
endpackage : wake_clock_pkg

// ### wake_detect_clock_sequencer.sv
// Clock source selection, standby gating and wake/detect status with Wishbone registers
//
// Function
// - The master clock starts on the bit-clock bypass and moves to the PLL only after 1 ms settling.
// - With the rate select bit at 0 the sample rate is the master clock divided by 250.
// - The mic and headphone wake mask bits suppress button and headphone wakes.
// - In latch mode 0 the active-low wake output goes low on a trigger and stays low until cleared.
// - Event select 1 shows sticky events, and latch-transfer 0 lets the sticky latches set.
// - The threshold level field holds the default detect percentage at 01 1111.
// - Status one reports tip insert, tip remove and the headset bias sense state.
// - Status two reports detect fall and rise plus mic short found and released.
//
// Design decision made here: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module wake_detect_clock_sequencer
  import wake_clock_pkg::*;
#(
  parameter int SETTLE_CYCLES = PLL_SETTLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Detect pins
  input wire logic tip_sense_i,
  input wire logic detect_i,
  input wire logic mic_short_i,
  input wire logic [1:0] bias_sense_i,
  // Clock, power and wake outputs
  output logic mclk_from_pll_o,
  output logic pll_enable_o,
  output logic sample_tick_o,
  output logic headset_clamp_off_o,
  output logic standby_o,
  output logic [5:0] threshold_o,
  output logic wakeup_n_o,
  output logic irq_o
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {CK_BYPASS, CK_SETTLE, CK_PLL} clk_state_t;
  localparam int SW = $clog2(SETTLE_CYCLES + 1);
  clk_state_t clk_state;
  logic [SW-1:0] settle_cnt;
  logic [8:0] rate_cnt;
  logic [7:0] mclk_ctrl, wake_ctrl, mic_ctrl, ev_mask, pwr_ctrl, ev_status;
  logic [4:0] pins_s, pins_d;
  logic tip, det, shrt;
  logic [1:0] bias;
  logic ev_insert, ev_remove, ev_rise, ev_fall, ev_short, ev_release;
  logic st_insert, st_remove, st_rise, st_fall, st_short, st_release;
  logic req, wr, rd, pll_ready_ev;
  logic [13:0] idx;
  logic [7:0] wbyte, stat_one, stat_two, next_dat;
  logic hp_trig, mic_trig;

  // Write-one-to-clear with set priority
  function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & ~clr);
  endfunction : sticky

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr = req & we_i & sel_i[0];
  assign rd = req & ~we_i;
  assign idx = adr_i[15:2];
  assign wbyte = dat_i[7:0];

  // One-cycle acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req;
    end
  end

  // ---------------------------------------------------------------
  // Writable registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mclk_ctrl <= RST_MASTER_CLOCK_CONTROL;
      wake_ctrl <= RST_WAKEUP_OUTPUT_CONTROL;
      mic_ctrl <= RST_MIC_DETECT_CONTROL;
      ev_mask <= RST_EVENT_MASK;
      pwr_ctrl <= RST_POWER_CONTROL;
    end else if (wr) begin
      case (idx)
        IDX_MASTER_CLOCK_CONTROL: mclk_ctrl <= wbyte & 8'h02;
        IDX_WAKEUP_OUTPUT_CONTROL: wake_ctrl <= wbyte & 8'hE1;
        IDX_MIC_DETECT_CONTROL_ONE: mic_ctrl <= wbyte;
        IDX_EVENT_MASK: ev_mask <= wbyte & 8'h7F;
        IDX_POWER_CONTROL: pwr_ctrl <= wbyte & 8'h07;
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisation and edge events
  // ---------------------------------------------------------------
  level_sync #(.WIDTH(5)) level_sync_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({bias_sense_i, mic_short_i, detect_i, tip_sense_i}),
    .sync_o(pins_s)
  );
  assign tip = pins_s[0];
  assign det = pins_s[1];
  assign shrt = pins_s[2];
  assign bias = pins_s[4:3];

  // Previous synchronised levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_d <= 5'h00;
    end else begin
      pins_d <= pins_s;
    end
  end
  assign ev_insert = tip & ~pins_d[0];
  assign ev_remove = ~tip & pins_d[0];
  assign ev_rise = det & ~pins_d[1];
  assign ev_fall = ~det & pins_d[1];
  assign ev_short = shrt & ~pins_d[2];
  assign ev_release = ~shrt & pins_d[2];

  // ---------------------------------------------------------------
  // Sticky detect latches, set only while transfer is 0, cleared on read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {st_insert, st_remove, st_rise, st_fall, st_short, st_release} <= 6'h00;
    end else begin
      st_insert <= sticky(st_insert, ev_insert & ~mic_ctrl[MDC_LATCH_XFER],
                          rd && idx == IDX_DETECT_STATUS_ONE);
      st_remove <= sticky(st_remove, ev_remove & ~mic_ctrl[MDC_LATCH_XFER],
                          rd && idx == IDX_DETECT_STATUS_ONE);
      st_rise <= sticky(st_rise, ev_rise & ~mic_ctrl[MDC_LATCH_XFER],
                        rd && idx == IDX_DETECT_STATUS_TWO);
      st_fall <= sticky(st_fall, ev_fall & ~mic_ctrl[MDC_LATCH_XFER],
                        rd && idx == IDX_DETECT_STATUS_TWO);
      st_short <= sticky(st_short, ev_short & ~mic_ctrl[MDC_LATCH_XFER],
                         rd && idx == IDX_DETECT_STATUS_TWO);
      st_release <= sticky(st_release, ev_release & ~mic_ctrl[MDC_LATCH_XFER],
                           rd && idx == IDX_DETECT_STATUS_TWO);
    end
  end

  // Sticky or live view of the detect status
  always_comb begin
    stat_one = 8'h00;
    stat_two = 8'h00;
    stat_one[S1_BIAS_HI -: 2] = bias;
    if (mic_ctrl[MDC_EVENT_SEL]) begin
      stat_one[S1_TIP_INSERT] = st_insert;
      stat_one[S1_TIP_REMOVE] = st_remove;
      stat_two[S2_FALL] = st_fall;
      stat_two[S2_RISE] = st_rise;
      stat_two[S2_SHORT_RELEASE] = st_release;
      stat_two[S2_SHORT_FOUND] = st_short;
    end else begin
      stat_one[S1_TIP_INSERT] = tip;
      stat_one[S1_TIP_REMOVE] = ~tip;
      stat_two[S2_FALL] = ~det;
      stat_two[S2_RISE] = det;
      stat_two[S2_SHORT_RELEASE] = ~shrt;
      stat_two[S2_SHORT_FOUND] = shrt;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    case (idx)
      IDX_MASTER_CLOCK_CONTROL: next_dat = mclk_ctrl;
      IDX_DETECT_STATUS_ONE: next_dat = stat_one;
      IDX_DETECT_STATUS_TWO: next_dat = stat_two;
      IDX_WAKEUP_OUTPUT_CONTROL: next_dat = wake_ctrl;
      IDX_MIC_DETECT_CONTROL_ONE: next_dat = mic_ctrl;
      IDX_EVENT_STATUS: next_dat = ev_status;
      IDX_EVENT_MASK: next_dat = ev_mask;
      IDX_POWER_CONTROL: next_dat = pwr_ctrl;
      IDX_CLOCK_STATUS: next_dat = {6'h00, clk_state == CK_SETTLE, mclk_from_pll_o};
      default: next_dat = 8'h00;
    endcase
  end

  // Registered read word, zero when idle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else begin
      dat_o <= rd ? {24'h00_0000, next_dat} : 32'h0000_0000;
    end
  end

  // ---------------------------------------------------------------
  // Master clock source: bypass first, PLL after settling
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_state <= CK_BYPASS;
      settle_cnt <= '0;
    end else begin
      case (clk_state)
        CK_BYPASS: begin
          settle_cnt <= '0;
          if (pwr_ctrl[PWR_PLL_ENABLE]) clk_state <= CK_SETTLE;
        end
        CK_SETTLE: begin
          settle_cnt <= settle_cnt + 1'b1;
          if (!pwr_ctrl[PWR_PLL_ENABLE]) clk_state <= CK_BYPASS;
          else if (settle_cnt == SW'(SETTLE_CYCLES - 1)) clk_state <= CK_PLL;
        end
        CK_PLL: begin
          if (!pwr_ctrl[PWR_PLL_ENABLE]) clk_state <= CK_BYPASS;
        end
        default: clk_state <= CK_BYPASS;
      endcase
    end
  end
  assign pll_ready_ev = clk_state == CK_SETTLE && pwr_ctrl[PWR_PLL_ENABLE]
                        && settle_cnt == SW'(SETTLE_CYCLES - 1);

  // Clock and power outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mclk_from_pll_o <= 1'b0;
      pll_enable_o <= 1'b0;
      headset_clamp_off_o <= 1'b0;
      standby_o <= 1'b0;
      threshold_o <= RST_MIC_DETECT_CONTROL[5:0];
    end else begin
      mclk_from_pll_o <= pll_ready_ev | (clk_state == CK_PLL && pwr_ctrl[PWR_PLL_ENABLE]);
      pll_enable_o <= pwr_ctrl[PWR_PLL_ENABLE];
      headset_clamp_off_o <= pwr_ctrl[PWR_CLAMP_OFF];
      standby_o <= pwr_ctrl[PWR_STANDBY_REQ] & pwr_ctrl[PWR_CLAMP_OFF];
      threshold_o <= mic_ctrl[5:0];
    end
  end

  // Sample-rate enable divider
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_cnt <= 9'h000;
      sample_tick_o <= 1'b0;
    end else if (rate_cnt >= (mclk_ctrl[MCC_RATE_SEL] ? 9'(RATE_DIV_HIGH - 1)
                                                      : 9'(RATE_DIV_LOW - 1))) begin
      rate_cnt <= 9'h000;
      sample_tick_o <= 1'b1;
    end else begin
      rate_cnt <= rate_cnt + 9'h001;
      sample_tick_o <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Wake output
  // ---------------------------------------------------------------
  assign hp_trig = (ev_insert | ev_remove) & ~wake_ctrl[WOC_MASK_HP];
  assign mic_trig = ev_short & ~wake_ctrl[WOC_MASK_MIC];

  // Latched low in mode 0, one pulse per trigger in mode 1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wakeup_n_o <= 1'b1;
    end else if (wake_ctrl[WOC_CLEAR]) begin
      wakeup_n_o <= 1'b1;
    end else if (hp_trig | mic_trig) begin
      wakeup_n_o <= 1'b0;
    end else if (wake_ctrl[WOC_LATCH_MODE]) begin
      wakeup_n_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Event status, mask and interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ev_status <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      for (int i = 0; i < 8; i++) begin
        ev_status[i] <= sticky(ev_status[i],
                               (i == EV_INSERT && ev_insert) || (i == EV_REMOVE && ev_remove) ||
                               (i == EV_RISE && ev_rise) || (i == EV_FALL && ev_fall) ||
                               (i == EV_SHORT && ev_short) || (i == EV_RELEASE && ev_release) ||
                               (i == EV_PLL_READY && pll_ready_ev),
                               wr && idx == IDX_EVENT_STATUS && wbyte[i]);
      end
      irq_o <= |(ev_status & ~ev_mask);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [8:0] gap;
  logic gap_ok;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap <= 9'h000;
      gap_ok <= 1'b0;
    end else begin
      gap <= sample_tick_o ? 9'h000 : gap + 9'h001;
      gap_ok <= mclk_ctrl[MCC_RATE_SEL] ? 1'b0 : (sample_tick_o | gap_ok);
    end
  end

  sequence hp_trigger_s;
    hp_trig && !wake_ctrl[WOC_CLEAR];
  endsequence
  sequence held_low_s;
    !wakeup_n_o && !wake_ctrl[WOC_CLEAR] && !wake_ctrl[WOC_LATCH_MODE];
  endsequence

  wake_goes_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    hp_trigger_s |=> !wakeup_n_o) else $error("wake output not asserted on trigger");
  wake_stays_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    held_low_s |=> !wakeup_n_o) else $error("latched wake output released early");
  wake_masked_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wakeup_n_o && wake_ctrl[WOC_MASK_HP] && wake_ctrl[WOC_MASK_MIC] |=> wakeup_n_o)
    else $error("masked wake source asserted wake output");
  pll_switch_time_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(mclk_from_pll_o) |-> $past(settle_cnt) == SW'(SETTLE_CYCLES - 1))
    else $error("clock moved to PLL before settling");
  rate_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_tick_o && gap_ok && !$past(mclk_ctrl[MCC_RATE_SEL]) |-> gap == 9'd249)
    else $error("sample tick period is not 250");
  sticky_insert_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_insert && !mic_ctrl[MDC_LATCH_XFER] |=> st_insert)
    else $error("insert event not latched");
  short_found_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_short && !mic_ctrl[MDC_LATCH_XFER] |=> st_short ##1 st_short || ack_o)
    else $error("short event not latched");
  threshold_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == IDX_MIC_DETECT_CONTROL_ONE |=> ##1 threshold_o == $past(wbyte[5:0], 2))
    else $error("threshold level not taken");
  ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("acknowledge longer than one cycle");
endmodule : wake_detect_clock_sequencer
`default_nettype wire

// ### wake_detect_clock_sequencer_tb.sv
// Self-checking testbench for the wake and clock sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHECK_EQ(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module wake_detect_clock_sequencer_tb;
  import wake_clock_pkg::*;
  localparam int SETTLE = 20;
  logic clk_i = 1'b0;
  logic rst_i, cyc, stb, we, ack, hung;
  logic [15:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  logic tip_sense_i, detect_i, mic_short_i;
  logic [1:0] bias_sense_i;
  logic mclk_from_pll_o, pll_enable_o, sample_tick_o, headset_clamp_off_o, standby_o;
  logic wakeup_n_o, irq_o;
  logic [5:0] threshold_o;
  int errors = 0;
  int tests_run = 0;
  logic stall = 1'b0;

  wake_detect_clock_sequencer #(.SETTLE_CYCLES(SETTLE)) wake_detect_clock_sequencer_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .tip_sense_i(tip_sense_i),
    .detect_i(detect_i), .mic_short_i(mic_short_i), .bias_sense_i(bias_sense_i),
    .mclk_from_pll_o(mclk_from_pll_o), .pll_enable_o(pll_enable_o),
    .sample_tick_o(sample_tick_o), .headset_clamp_off_o(headset_clamp_off_o),
    .standby_o(standby_o), .threshold_o(threshold_o), .wakeup_n_o(wakeup_n_o), .irq_o(irq_o));

  wake_host_model wake_host_model_i (
    .clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(dat_w), .dat_i(dat_r), .ack_i(ack), .hung_o(hung));

  // 50 MHz clock
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    if (errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cycles

  task automatic expect_reg(input logic [13:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] v;
    wake_host_model_i.rd(idx, v);
    `CHECK_EQ(what, exp, v)
  endtask : expect_reg

  task automatic wait_wake(input logic exp);
    int n;
    n = 0;
    while (wakeup_n_o !== exp && n < 10) begin
      @(posedge clk_i);
      n++;
    end
    if (wakeup_n_o !== exp) stall <= 1'b1;
    `CHECK_EQ("wakeup_n_o", exp, wakeup_n_o)
  endtask : wait_wake

  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    do begin @(posedge clk_i); n++; end while (sample_tick_o !== 1'b1 && n < 600);
    n = 0;
    do begin @(posedge clk_i); n++; end while (sample_tick_o !== 1'b1 && n < 600);
    if (sample_tick_o !== 1'b1) stall <= 1'b1;
    gap = n;
  endtask : tick_gap

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    `CHECK_EQ("bypass", 1'b0, mclk_from_pll_o)
    `CHECK_EQ("threshold", 6'h1F, threshold_o)
    `CHECK_EQ("wake idle", 1'b1, wakeup_n_o)
    expect_reg(IDX_MASTER_CLOCK_CONTROL, RST_MASTER_CLOCK_CONTROL, "mclk ctrl");
    expect_reg(IDX_WAKEUP_OUTPUT_CONTROL, RST_WAKEUP_OUTPUT_CONTROL, "wake ctrl");
    expect_reg(IDX_MIC_DETECT_CONTROL_ONE, RST_MIC_DETECT_CONTROL, "mic ctrl");
    expect_reg(IDX_EVENT_MASK, RST_EVENT_MASK, "mask");
    expect_reg(IDX_EVENT_STATUS, 8'h00, "status");
    wake_host_model_i.wr(14'h0000, 8'h5A);
    expect_reg(14'h0000, 8'h00, "unmapped");
  endtask : t_reset

  task automatic t_rate();
    int gap;
    wake_host_model_i.start_clock();
    tick_gap(gap);
    `CHECK_EQ("gap 250", 250, gap)
    wake_host_model_i.wr(IDX_MASTER_CLOCK_CONTROL, 8'h02);
    tick_gap(gap);
    `CHECK_EQ("gap 256", 256, gap)
    wake_host_model_i.start_clock();
  endtask : t_rate

  task automatic t_pll_standby();
    int n;
    wake_host_model_i.enable_pll();
    expect_reg(IDX_CLOCK_STATUS, 8'h02, "settling");
    `CHECK_EQ("pll enable", 1'b1, pll_enable_o)
    cycles(SETTLE - 6);
    `CHECK_EQ("early switch", 1'b0, mclk_from_pll_o)
    n = 0;
    while (mclk_from_pll_o !== 1'b1 && n < 10) begin @(posedge clk_i); n++; end
    if (mclk_from_pll_o !== 1'b1) stall <= 1'b1;
    `CHECK_EQ("on pll", 1'b1, mclk_from_pll_o)
    expect_reg(IDX_EVENT_STATUS, 8'h40, "pll ready");
    wake_host_model_i.wr(IDX_EVENT_STATUS, 8'h40);
    expect_reg(IDX_EVENT_STATUS, 8'h00, "w1c");
    wake_host_model_i.wr(IDX_POWER_CONTROL, 8'h05);
    cycles(2);
    `CHECK_EQ("standby no clamp", 1'b0, standby_o)
    wake_host_model_i.enter_standby();
    cycles(2);
    `CHECK_EQ("standby", 1'b1, standby_o)
    `CHECK_EQ("clamp", 1'b1, headset_clamp_off_o)
  endtask : t_pll_standby

  task automatic t_wake();
    int highs;
    wake_host_model_i.arm_detect();
    wake_host_model_i.wr(IDX_WAKEUP_OUTPUT_CONTROL, 8'h80);
    bias_sense_i <= 2'b10;
    tip_sense_i <= 1'b1;
    wait_wake(1'b0);
    highs = 0;
    repeat (40) begin @(posedge clk_i); if (wakeup_n_o !== 1'b0) highs++; end
    `CHECK_EQ("wake latched", 0, highs)
    `CHECK_EQ("irq masked", 1'b0, irq_o)
    wake_host_model_i.wr(IDX_EVENT_MASK, 8'hFE);
    cycles(3);
    `CHECK_EQ("irq raised", 1'b1, irq_o)
    wake_host_model_i.leave_standby();
    cycles(2);
    `CHECK_EQ("awake", 1'b0, standby_o)
    expect_reg(IDX_DETECT_STATUS_ONE, 8'hA0, "insert");
    expect_reg(IDX_DETECT_STATUS_ONE, 8'h80, "insert read");
    wake_host_model_i.wr(IDX_EVENT_STATUS, 8'h01);
    cycles(3);
    `CHECK_EQ("irq cleared", 1'b0, irq_o)
    wake_host_model_i.clear_wake(8'h80);
    wait_wake(1'b1);
    wake_host_model_i.wr(IDX_WAKEUP_OUTPUT_CONTROL, 8'hC0);
    tip_sense_i <= 1'b0;
    cycles(10);
    `CHECK_EQ("hp masked", 1'b1, wakeup_n_o)
    expect_reg(IDX_DETECT_STATUS_ONE, 8'h90, "remove");
    wake_host_model_i.wr(IDX_WAKEUP_OUTPUT_CONTROL, 8'h40);
    mic_short_i <= 1'b1;
    wait_wake(1'b0);
    expect_reg(IDX_DETECT_STATUS_TWO, 8'h08, "short found");
    wake_host_model_i.clear_wake(8'hC0);
  endtask : t_wake

  task automatic t_status_two();
    mic_short_i <= 1'b0;
    cycles(8);
    expect_reg(IDX_DETECT_STATUS_TWO, 8'h10, "short release");
    detect_i <= 1'b1;
    cycles(8);
    expect_reg(IDX_DETECT_STATUS_TWO, 8'h40, "rise");
    detect_i <= 1'b0;
    cycles(8);
    expect_reg(IDX_DETECT_STATUS_TWO, 8'h80, "fall");
    wake_host_model_i.wr(IDX_MIC_DETECT_CONTROL_ONE, 8'hDF);
    detect_i <= 1'b1;
    cycles(8);
    expect_reg(IDX_DETECT_STATUS_TWO, 8'h00, "latch held");
    wake_host_model_i.wr(IDX_WAKEUP_OUTPUT_CONTROL, 8'hA0);
    tip_sense_i <= 1'b1;
    wait_wake(1'b0);
    @(posedge clk_i);
    `CHECK_EQ("wake pulse", 1'b1, wakeup_n_o)
  endtask : t_status_two

  // Hung bus or a wait out of bound ends the run
  always @(posedge hung or posedge stall) begin
    errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    tip_sense_i = 1'b0;
    detect_i = 1'b0;
    mic_short_i = 1'b0;
    bias_sense_i = 2'b00;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_rate();
    t_pll_standby();
    t_wake();
    t_status_two();
    tally_and_finish();
  end
endmodule : wake_detect_clock_sequencer_tb
`default_nettype wire

// ### wake_host_model.sv
// Host model: Wishbone master and the host's wake and power procedures
`timescale 1ns/10ps
`default_nettype none
module wake_host_model
  import wake_clock_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Wishbone master
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [15:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  // Raised when a slave never answers
  output logic hung_o
);
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 16'h0000;
    sel_o = 4'hF;
    dat_o = 32'h0000_0000;
    hung_o = 1'b0;
  end

  // One classic cycle, held until ack is sampled, then released
  task automatic bus_cycle(input logic w, input logic [13:0] idx, input logic [7:0] wd,
                           output logic [7:0] rd);
    int n;
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= {idx, 2'b00};
    dat_o <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 50);
    rd = dat_i[7:0];
    if (ack_i !== 1'b1) hung_o <= 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= ~adr_o; // Released lines carry no stale value
    dat_o <= ~dat_o;
  endtask : bus_cycle

  task automatic wr(input logic [13:0] idx, input logic [7:0] d);
    logic [7:0] x;
    bus_cycle(1'b1, idx, d, x);
  endtask : wr

  task automatic rd(input logic [13:0] idx, output logic [7:0] d);
    bus_cycle(1'b0, idx, 8'h00, d);
  endtask : rd

  // Reference clock is present before the master clock is enabled
  task automatic start_clock();
    wr(IDX_MASTER_CLOCK_CONTROL, 8'h00);
  endtask : start_clock

  // Odd bit clock rate: turn the PLL on
  task automatic enable_pll();
    wr(IDX_POWER_CONTROL, 8'h01);
  endtask : enable_pll

  // Clamps go off before standby is requested
  task automatic enter_standby();
    wr(IDX_POWER_CONTROL, 8'h03);
    wr(IDX_POWER_CONTROL, 8'h07);
  endtask : enter_standby

  // Wake answered by leaving standby
  task automatic leave_standby();
    wr(IDX_POWER_CONTROL, 8'h01);
  endtask : leave_standby

  // Sticky events selected before status is read
  task automatic arm_detect();
    wr(IDX_MIC_DETECT_CONTROL_ONE, 8'h5F);
  endtask : arm_detect

  // Clear bit set, then released
  task automatic clear_wake(input logic [7:0] masks);
    wr(IDX_WAKEUP_OUTPUT_CONTROL, masks | 8'h01);
    wr(IDX_WAKEUP_OUTPUT_CONTROL, masks);
  endtask : clear_wake
endmodule : wake_host_model
`default_nettype wire
